// File: rtl/rxr_engine.sv
// The Avalon-MM interface to the registers was left to the implementer.
module rxr_engine #(
    parameter int NQ = 2                                  // receive queues
) (
    input  wire logic        clk_sys,          // system clock
    input  wire logic        srst,             // sync reset, high
    input  wire logic [15:0] avs_address,      // byte address
    input  wire logic        avs_read,         // read request
    input  wire logic        avs_write,        // write request
    input  wire logic [31:0] avs_writedata,    // write data
    output logic      [31:0] avs_readdata,     // read data
    output logic             avs_waitrequest,  // stall
    input  wire logic        rx_enable,        // receive enable bit
    input  wire logic [7:0]  cl_desc,          // cache line in descriptors
    input  wire logic        pkt_done,         // packet in memory
    input  wire logic        abs_fire,         // absolute timer fired
    output logic    [NQ-1:0] fetch_req,        // prefetch wanted
    input  wire logic [NQ-1:0] fetch_ack,      // one descriptor fetched
    input  wire logic [NQ-1:0] desc_done,      // one descriptor processed
    output logic    [NQ-1:0] wb_req,           // write-back wanted
    input  wire logic [NQ-1:0] wb_ack,         // all pending written back
    output logic             timer_cause       // receive timer cause
);
    import rxr_pkg::*;

    // address match for a queue
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off,
                                 input int q);
        return a == off + 16'(q) * Q_STRIDE;
    endfunction
    // threshold to descriptors
    function automatic logic [13:0] to_desc(input logic [5:0] v, input logic u,
                                            input logic [7:0] cl);
        return u ? {8'h00, v} : v * cl;
    endfunction
    logic        ack_reg, ack_next;                 // one wait cycle done
    logic [31:0] rd_reg, rd_next;                   // read data
    logic        wr_acc;                            // write taken
    logic [15:0] a;                                 // address alias
    logic [31:0] wd;                                // data alias
    logic [12:0] len_reg [NQ], len_next [NQ];       // ring length field
    logic [15:0] head_reg [NQ], head_next [NQ];     // head pointer
    logic [15:0] tail_reg [NQ], tail_next [NQ];     // tail pointer
    rxr_thr_s    thr_reg [NQ], thr_next [NQ];       // thresholds
    logic [6:0]  on_reg [NQ], on_next [NQ];         // on-chip unprocessed
    logic [6:0]  wbc_reg [NQ], wbc_next [NQ];       // ready for write-back
    logic [NQ-1:0] fl_reg, fl_next;                 // flush pending
    logic [15:0] avail [NQ];                        // free in host memory
    logic [13:0] pth [NQ], hth [NQ], wth [NQ];      // levels in descriptors
    rxr_tm_e     tm_reg, tm_next;                   // countdown state
    logic [15:0] dly_reg, dly_next;                 // packet delay value
    logic [15:0] cnt_reg, cnt_next;                 // countdown
    logic [6:0]  pre_reg, pre_next;                 // tick prescaler
    logic        cause_reg, cause_next;             // timer cause pulse
    logic        expire, fpd_wr;                    // expired, flush bit written
    assign a  = avs_address;
    assign wd = avs_writedata;
    assign wr_acc = ack_reg & avs_write;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rd_reg;
    assign timer_cause  = cause_reg;

    // bus slave: one wait cycle, readback mux
    always_comb
    begin
        ack_next = (avs_read | avs_write) & ~ack_reg;
        rd_next  = rd_reg;
        if (ack_next)
        begin
            rd_next = 32'h0000_0000;                      // unmapped reads zero
            for (int q = 0; q < NQ; q++)
            begin
                if (hit(a, A_LEN, q))
                    rd_next = {12'h000, len_reg[q], 7'h00};
                if (hit(a, A_HEAD, q))
                    rd_next = {16'h0000, head_reg[q]};
                if (hit(a, A_TAIL, q))
                    rd_next = {16'h0000, tail_reg[q]};
                if (hit(a, A_THR, q))
                    rd_next = {7'h00, thr_reg[q].unit, 2'h0, thr_reg[q].wb, 2'h0,
                               thr_reg[q].host, 2'h0, thr_reg[q].pre};
            end
            if (a == A_DLY)
                rd_next = {16'h0000, dly_reg};
        end
    end

    // bus registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ack_reg <= 1'b0;
            rd_reg  <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= ack_next;
            rd_reg  <= rd_next;
        end
    end

    // per-queue ring state
    always_comb
    begin
        for (int q = 0; q < NQ; q++)
        begin
            len_next[q]  = len_reg[q];
            head_next[q] = head_reg[q];
            tail_next[q] = tail_reg[q];
            thr_next[q]  = thr_reg[q];
            on_next[q]   = on_reg[q];
            wbc_next[q]  = wbc_reg[q];
            pth[q] = to_desc(thr_reg[q].pre, thr_reg[q].unit, cl_desc);
            hth[q] = to_desc(thr_reg[q].host, thr_reg[q].unit, cl_desc);
            wth[q] = to_desc(thr_reg[q].wb, thr_reg[q].unit, cl_desc);
            // free count, head equal tail means none
            if (tail_reg[q] >= head_reg[q])
                avail[q] = tail_reg[q] - head_reg[q];
            else
                avail[q] = tail_reg[q] + {len_reg[q], 3'b000} - head_reg[q];
            fetch_req[q] = rx_enable && ({7'h00, on_reg[q]} < pth[q])
                           && ({2'b00, hth[q]} <= avail[q]) && (avail[q] != 16'h0000);
            wb_req[q] = (wbc_reg[q] != 7'h00)
                        && (fl_reg[q] || ({7'h00, wbc_reg[q]} >= wth[q]));
            fl_next[q] = expire | abs_fire | (fl_reg[q] & ~wb_ack[q]);
            // software writes
            if (wr_acc && hit(a, A_LEN, q))
                len_next[q] = wd[LEN_MSB:LEN_LSB];
            if (wr_acc && hit(a, A_TAIL, q))
                tail_next[q] = wd[15:0];
            if (wr_acc && (hit(a, A_THR, q) || (q == 1 && hit(a, A_THR, 0))))
            begin
                thr_next[q].unit = wd[UNIT_BIT];
                thr_next[q].wb   = wd[WB_LSB+5:WB_LSB];
                thr_next[q].host = wd[HOST_LSB+5:HOST_LSB];
                thr_next[q].pre  = wd[5:0];
            end
            // head advance with wrap, or software load
            if (wr_acc && hit(a, A_HEAD, q))
                head_next[q] = wd[15:0];
            else if (fetch_ack[q] && fetch_req[q])
            begin
                if (head_reg[q] + 16'h0001 >= {len_reg[q], 3'b000})
                    head_next[q] = 16'h0000;
                else
                    head_next[q] = head_reg[q] + 16'h0001;
            end
            // on-chip count
            case ({fetch_ack[q] & fetch_req[q], desc_done[q]})
                2'b10:   on_next[q] = on_reg[q] + 7'h01;
                2'b01:   on_next[q] = on_reg[q] - 7'h01;
                default: on_next[q] = on_reg[q];
            endcase
            // write-back count, ack clears it; a new descriptor in the same cycle restarts it at one
            if (wb_ack[q])
                wbc_next[q] = {6'h00, desc_done[q]};
            else if (desc_done[q])
                wbc_next[q] = wbc_reg[q] + 7'h01;
        end
    end

    // per-queue registers
    always_ff @(posedge clk_sys)
    begin
        for (int q = 0; q < NQ; q++)
        begin
            if (srst)
            begin
                len_reg[q]  <= 13'h0000;
                head_reg[q] <= 16'h0000;
                tail_reg[q] <= 16'h0000;
                thr_reg[q]  <= '{unit: 1'b0, wb: WB_RST, host: 6'h00, pre: 6'h00};
                on_reg[q]   <= 7'h00;
                wbc_reg[q]  <= 7'h00;
                fl_reg[q]   <= 1'b0;
            end
            else
            begin
                len_reg[q]  <= len_next[q];
                head_reg[q] <= head_next[q];
                tail_reg[q] <= tail_next[q];
                thr_reg[q]  <= thr_next[q];
                on_reg[q]   <= on_next[q];
                wbc_reg[q]  <= wbc_next[q];
                fl_reg[q]   <= fl_next[q];
            end
        end
    end

    // packet delay countdown
    always_comb
    begin
        tm_next  = tm_reg;
        cnt_next = cnt_reg;
        pre_next = pre_reg;
        expire   = 1'b0;
        dly_next = dly_reg;
        fpd_wr   = wr_acc && (a == A_DLY) && wd[FPD_BIT];
        if (wr_acc && a == A_DLY)
            dly_next = wd[15:0];
        case (tm_reg)
            TM_RUN:
            begin
                pre_next = (pre_reg == TICK_CYC - 7'h01) ? 7'h00 : pre_reg + 7'h01;
                if (pre_reg == TICK_CYC - 7'h01)
                begin
                    cnt_next = cnt_reg - 16'h0001;
                    if (cnt_reg <= 16'h0001)
                    begin
                        expire  = 1'b1;
                        tm_next = TM_IDLE;
                    end
                end
            end
            TM_IDLE: pre_next = 7'h00;
            default: tm_next = TM_IDLE;
        endcase
        if (abs_fire)
        begin
            expire   = 1'b0;
            tm_next  = TM_IDLE;
            cnt_next = dly_reg;
            pre_next = 7'h00;
        end
        if (pkt_done)
        begin
            if (dly_reg == 16'h0000)
                expire = 1'b1;
            else
            begin
                tm_next  = TM_RUN;
                cnt_next = dly_reg;
                pre_next = 7'h00;
            end
        end
        if (fpd_wr)
        begin
            expire  = 1'b1;
            tm_next = TM_IDLE;
        end
        cause_next = expire;
    end

    // countdown registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            tm_reg    <= TM_IDLE;
            dly_reg   <= 16'h0000;
            cnt_reg   <= 16'h0000;
            pre_reg   <= 7'h00;
            cause_reg <= 1'b0;
        end
        else
        begin
            tm_reg    <= tm_next;
            dly_reg   <= dly_next;
            cnt_reg   <= cnt_next;
            pre_reg   <= pre_next;
            cause_reg <= cause_next;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_len_low;
        ack_next && avs_read && hit(a, A_LEN, 0) |=> rd_reg[6:0] == 7'h00;
    endproperty
    a_len_low: assert property (p_len_low) else $error("length low bits read nonzero");
    property p_head_step;
        fetch_ack[0] && fetch_req[0] && !(wr_acc && hit(a, A_HEAD, 0)) |=>
            head_reg[0] == ((($past(head_reg[0]) + 16'h0001) >= {len_reg[0], 3'b000})
                            ? 16'h0000 : $past(head_reg[0]) + 16'h0001);
    endproperty
    a_head_step: assert property (p_head_step) else $error("head did not step or wrap");
    property p_reload;
        pkt_done && !abs_fire && !fpd_wr && dly_reg != 16'h0000 |=>
            tm_reg == TM_RUN && cnt_reg == $past(dly_reg) && pre_reg == 7'h00;
    endproperty
    a_reload: assert property (p_reload) else $error("countdown not reloaded");
    property p_expire;
        expire |=> cause_reg && fl_reg == {NQ{1'b1}};
    endproperty
    a_expire: assert property (p_expire) else $error("expiry missed cause or flush");
    property p_zero_dly;
        pkt_done && dly_reg == 16'h0000 |=> cause_reg;
    endproperty
    a_zero_dly: assert property (p_zero_dly) else $error("no immediate cause");
    property p_fpd;
        fpd_wr |=> cause_reg && tm_reg == TM_IDLE && fl_reg == {NQ{1'b1}};
    endproperty
    a_fpd: assert property (p_fpd) else $error("flush bit misbehaved");
    property p_abs;
        abs_fire && !pkt_done && !fpd_wr |=> tm_reg == TM_IDLE && !cause_reg
            && cnt_reg == $past(dly_reg);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute fire did not halt");
    property p_copy;
        wr_acc && hit(a, A_THR, 0) |=> thr_reg[1] == thr_reg[0];
    endproperty
    a_copy: assert property (p_copy) else $error("queue 1 thresholds not copied");
    property p_fetch;
        fetch_req[0] |-> {7'h00, on_reg[0]} < pth[0] && {2'b00, hth[0]} <= avail[0]
            && avail[0] != 16'h0000 && rx_enable;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch outside thresholds");
    property p_wb;
        wb_req[0] && !fl_reg[0] |-> {7'h00, wbc_reg[0]} >= wth[0];
    endproperty
    a_wb: assert property (p_wb) else $error("early write-back");
    property p_wb_rst;
        $past(srst) && !srst |-> thr_reg[0].wb == WB_RST && thr_reg[1].wb == WB_RST;
    endproperty
    a_wb_rst: assert property (p_wb_rst) else $error("write-back level reset wrong");
endmodule

// File: rtl/rxr_pkg.sv
package rxr_pkg;
    // register byte offsets, queue 0
    localparam logic [15:0] A_LEN    = 16'h2808;
    localparam logic [15:0] A_HEAD   = 16'h2810;
    localparam logic [15:0] A_TAIL   = 16'h2818;
    localparam logic [15:0] A_DLY    = 16'h2820;
    localparam logic [15:0] A_THR    = 16'h2828;
    localparam logic [15:0] Q_STRIDE = 16'h0100;
    // field positions
    localparam int LEN_LSB  = 7;
    localparam int LEN_MSB  = 19;
    localparam int FPD_BIT  = 31;
    localparam int HOST_LSB = 8;
    localparam int WB_LSB   = 16;
    localparam int UNIT_BIT = 24;
    // reset values
    localparam logic [5:0] WB_RST = 6'h01;
    // delay tick: 1.024 us at 100 MHz, rounded down
    localparam int TICK_NS = 1024;
    localparam int CLK_MHZ = 100;
    localparam logic [6:0] TICK_CYC = 7'(TICK_NS * CLK_MHZ / 1000);
    // threshold control fields
    typedef struct packed {
        logic       unit;
        logic [5:0] wb;
        logic [5:0] host;
        logic [5:0] pre;
    } rxr_thr_s;
    // packet delay countdown states
    typedef enum logic [1:0] {
        TM_IDLE = 2'b01,
        TM_RUN  = 2'b10
    } rxr_tm_e;
endpackage

// File: verif/rxr_host_model.sv
// host memory side: answers prefetch and write-back requests
module rxr_host_model #(
    parameter int WB_LAT = 4                 // cycles before write-back completes
) (
    input  wire logic       clk_sys,         // system clock
    input  wire logic       srst,            // sync reset, high
    input  wire logic [1:0] fetch_req,       // prefetch wanted
    output logic      [1:0] fetch_ack,       // one descriptor fetched
    input  wire logic [1:0] wb_req,          // write-back wanted
    output logic      [1:0] wb_ack           // pending written back
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wb_cnt [2];                  // cycles a write-back has waited
    // fetch every other cycle while asked; slow write-back completion
    always_ff @(posedge clk_sys)
    begin
        for (int q = 0; q < 2; q++)
        begin
            fetch_ack[q] <= !srst && fetch_req[q] && !fetch_ack[q];
            wb_cnt[q] <= (srst || !wb_req[q] || wb_ack[q]) ? 3'h0 : wb_cnt[q] + 3'h1;
            wb_ack[q] <= !srst && wb_req[q] && wb_cnt[q] == 3'(WB_LAT);
        end
    end
endmodule

// File: verif/tb_rx_descriptor_ring_engine.sv
module tb_rx_descriptor_ring_engine;
    timeunit 1ns;
    timeprecision 1ps;
    import rxr_pkg::*;
    logic        clk_sys = 1'b0;          // system clock
    logic        srst = 1'b1;             // sync reset
    logic [15:0] avs_address = 16'h0000;  // bus address
    logic        avs_read = 1'b0;         // bus read
    logic        avs_write = 1'b0;        // bus write
    logic [31:0] avs_writedata = 32'h0;   // bus write data
    logic [31:0] avs_readdata;            // bus read data
    logic        avs_waitrequest;         // bus stall
    logic        rx_enable = 1'b0;        // receive enable
    logic [7:0]  cl_desc = 8'h01;         // cache line in descriptors
    logic        pkt_done = 1'b0;         // packet delivered
    logic        abs_fire = 1'b0;         // absolute timer fired
    logic [1:0]  desc_done = 2'b00;       // descriptor processed
    logic [1:0]  fetch_req;               // prefetch wanted
    logic [1:0]  fetch_ack;               // descriptor fetched
    logic [1:0]  wb_req;                  // write-back wanted
    logic [1:0]  wb_ack;                  // write-back done
    logic        timer_cause;             // timer cause pulse
    logic [31:0] rd_q;                    // last read data
    int          fails = 0;               // mismatches
    int          cmp_count = 0;           // comparisons
    int          cyc = 0;                 // cycle count for timeout
    int          n;                       // measured cycles
    always #5 clk_sys = ~clk_sys;
    rxr_engine #(.NQ(2)) u_rxr_engine (.clk_sys(clk_sys), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_enable(rx_enable), .cl_desc(cl_desc),
        .pkt_done(pkt_done), .abs_fire(abs_fire), .fetch_req(fetch_req),
        .fetch_ack(fetch_ack), .desc_done(desc_done), .wb_req(wb_req), .wb_ack(wb_ack),
        .timer_cause(timer_cause));
    rxr_host_model #(.WB_LAT(4)) u_rxr_host_model (.clk_sys(clk_sys), .srst(srst),
        .fetch_req(fetch_req), .fetch_ack(fetch_ack), .wb_req(wb_req), .wb_ack(wb_ack));
    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    endtask
    // one-cycle pulse: 0 packet, 1 absolute timer, else queue 0 descriptor done
    task automatic fire(input int k);
        case (k)
            0: pkt_done <= 1'b1;
            1: abs_fire <= 1'b1;
            default: desc_done <= 2'b01;
        endcase
        @(posedge clk_sys);
        pkt_done <= 1'b0;
        abs_fire <= 1'b0;
        desc_done <= 2'b00;
    endtask
    task automatic wait_cause(input int lim);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (timer_cause !== 1'b1 && n <= lim);
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        rx_enable <= 1'b0;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
    endtask
    // reset values, masking, queue spacing, threshold copy
    task automatic s_regs();
        for (int q = 0; q < 2; q++)
        begin
            rd("len", A_LEN + 16'(q * 256), 32'h0);
            rd("head", A_HEAD + 16'(q * 256), 32'h0);
            rd("tail", A_TAIL + 16'(q * 256), 32'h0);
            rd("thr", A_THR + 16'(q * 256), 32'h00010000);
        end
        rd("delay", A_DLY, 32'h0);
        bus(1'b1, A_LEN, 32'hffffffff);
        rd("len mask", A_LEN, 32'h000fff80);
        rd("len q1", A_LEN + Q_STRIDE, 32'h0);
        bus(1'b1, A_TAIL + Q_STRIDE, 32'h5);
        rd("tail q1", A_TAIL + Q_STRIDE, 32'h5);
        rd("tail q0", A_TAIL, 32'h0);
        bus(1'b1, 16'h3000, 32'hffffffff);
        rd("unmapped", 16'h3000, 32'h0);
        bus(1'b1, A_THR, 32'h01030204);
        rd("thr copy", A_THR + Q_STRIDE, 32'h01030204);
        bus(1'b1, A_THR + Q_STRIDE, 32'h00020101);
        rd("thr q0 kept", A_THR, 32'h01030204);
    endtask
    // zero delay, flush bit, countdown, reload, absolute halt
    task automatic s_timer();
        fire(0);
        wait_cause(5);
        chk("zero delay", 32'h1, 32'(n));
        bus(1'b1, A_DLY, 32'h80000001);
        wait_cause(5);
        chk("flush", 32'h1, 32'(n));
        rd("flush reads 0", A_DLY, 32'h1);
        fire(0);
        wait_cause(200);
        chk("delay one", 32'(TICK_CYC) + 32'h1, 32'(n));
        fire(0);
        repeat (50) @(posedge clk_sys);
        fire(0);
        wait_cause(200);
        chk("reload", 32'(TICK_CYC) + 32'h1, 32'(n));
        fire(0);
        repeat (20) @(posedge clk_sys);
        fire(1);
        wait_cause(300);
        chk("abs halt", 32'd301, 32'(n));
        fire(0);
        wait_cause(200);
        chk("restart", 32'(TICK_CYC) + 32'h1, 32'(n));
    endtask
    // prefetch across the ring end, then host level gating
    task automatic s_fetch();
        do_reset();
        bus(1'b1, A_LEN, 32'h80);
        bus(1'b1, A_HEAD, 32'h6);
        bus(1'b1, A_TAIL, 32'h2);
        bus(1'b1, A_THR, 32'h0100012f);
        rx_enable <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd("head wrap", A_HEAD, 32'h2);
        rd("head q1", A_HEAD + Q_STRIDE, 32'h0);
        do_reset();
        bus(1'b1, A_LEN, 32'h80);
        bus(1'b1, A_TAIL, 32'h2);
        bus(1'b1, A_THR, 32'h0100032f);
        rx_enable <= 1'b1;
        repeat (30) @(posedge clk_sys);
        rd("host short", A_HEAD, 32'h0);
        bus(1'b1, A_TAIL, 32'h3);
        repeat (30) @(posedge clk_sys);
        rd("host met", A_HEAD, 32'h1);
    endtask
    // cache-line units, write-back level, flush on packet delay expiry
    task automatic s_wb();
        do_reset();
        cl_desc <= 8'h02;
        bus(1'b1, A_LEN, 32'h80);
        bus(1'b1, A_DLY, 32'h1);
        bus(1'b1, A_TAIL, 32'h4);
        bus(1'b1, A_THR, 32'h00010102);
        rx_enable <= 1'b1;
        repeat (30) @(posedge clk_sys);
        rd("line units", A_HEAD, 32'h3);
        fire(2);
        @(posedge clk_sys);
        chk("wb below", 32'h0, 32'(wb_req));
        fire(2);
        @(posedge clk_sys);
        chk("wb level", 32'h1, 32'(wb_req));
        repeat (10) @(posedge clk_sys);
        chk("wb done", 32'h0, 32'(wb_req));
        fire(2);
        @(posedge clk_sys);
        chk("wb one", 32'h0, 32'(wb_req));
        fire(0);
        wait_cause(200);
        chk("wb flush time", 32'(TICK_CYC) + 32'h1, 32'(n));
        chk("wb flush", 32'h1, 32'(wb_req));
    endtask
    initial
    begin
        do_reset();
        s_regs();
        s_timer();
        s_fetch();
        s_wb();
        complete_run();
    end
endmodule
